// ---- core/ebt_regs.svh ----
/*
 * Constants of the external bus cycle timing block: layout of one
 * chip-select timing configuration word, timing figures, buffer depth.
 * Assumes inclusion by bare name from the buffer and sequencer design files.
 */
`ifndef EBT_REGS_SVH
`define EBT_REGS_SVH

// chip-select timing configuration word, one per chip select
`define EBT_CFG_W          16
`define EBT_CFG_AB_BASE    0
`define EBT_CFG_AB_EXT_LO  1
`define EBT_CFG_C_LO       3
`define EBT_CFG_D          5
`define EBT_CFG_E_LO       6
`define EBT_CFG_F_LO       11
`define EBT_CFG_RDY_EN     13
`define EBT_CFG_RDY_POL    14
`define EBT_CFG_RDY_ASYNC  15
`define EBT_CFG_RST        16'h0000

// least distance of two bus signal transitions, picoseconds
`define EBT_MIN_GAP_PS     12500
// default link clock period, picoseconds
`define EBT_LINK_PERIOD_PS 160000
// link cycles per reference clock period (toggle divider)
`define EBT_REF_CYC        2

`define EBT_BUF_DEPTH      2
`define EBT_ADDR_RST       24'h000000
`define EBT_DATA_RST       16'h0000

`endif

// ---- core/ebt_pkg.sv ----
/*
 * Types shared by the external bus cycle timing block.
 * Assumes ebt_regs.svh is on the include path.
 */
package ebt_pkg;

    typedef enum logic [2:0] {
        EBT_IDLE,
        EBT_ADDR_SETUP,
        EBT_CMD_DELAY,
        EBT_WDATA_SETUP,
        EBT_ACCESS,
        EBT_READY_WAIT,
        EBT_HOLD
    } ebt_phase_t;

    // one queued bus request; cfg is the selected chip_select_timing_cfg
    typedef struct packed {
        logic [15:0] cfg;
        logic        mux;
        logic [2:0]  cs;
        logic [1:0]  be;
        logic        write;
        logic [15:0] wdata;
        logic [23:0] addr;
    } ebt_req_t;

endpackage

// ---- core/ebt_buf.sv ----
/*
 * Small request buffer: DEPTH entries of WIDTH bits, valid/ready on both
 * sides. Assumes a single clock; i_en low freezes it.
 */
`timescale 1ns/1ns
`include "ebt_regs.svh"

module ebt_buf #(
    parameter int WIDTH = 63,
    parameter int DEPTH = `EBT_BUF_DEPTH
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_en,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wptr_q;
    logic [PW-1:0]    rptr_q;
    logic [PW:0]      cnt_q;
    logic [PW:0]      cnt_d;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_valid = (cnt_q != '0);
    assign o_data  = mem_q[rptr_q];

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            cnt_q   <= '0;
            o_ready <= 1'b0;
        end else if (i_en) begin
            cnt_q   <= cnt_d;
            // registered ready: full is known one cycle ahead
            o_ready <= (cnt_d != (PW+1)'(DEPTH));
            if (push) begin
                wptr_q <= ptr_inc(wptr_q);
            end
            if (pop) begin
                rptr_q <= ptr_inc(rptr_q);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_en && push) begin
            mem_q[wptr_q] <= i_data;
        end
    end

endmodule

// ---- core/ebt_ctrl.sv ----
/*
 * External bus cycle sequencer: takes requests on the system clock, runs
 * five-phase multiplexed or demultiplexed bus cycles on the link clock.
 * Assumes quasi-static configuration inputs, external pins asynchronous
 * to both clocks, and a free-running link clock.
 */
// Operation
// - five phases in order: AB, C, D, E, F
// - per-chip-select phase lengths, access 1 to 32
// - setup 1-2 units, plus 0-3 on window change
// - command delay, hold 0-3; data setup 0-1
// - ready input can stretch the access phase
// - transitions at least 12.5 ns apart above 80 MHz
// - reference clock output accompanies bus cycles
// - read data captured when read strobe rises
// - early address change cannot corrupt read data
// - mux mode: address then data on shared bus
// - demux: 24-bit address lines, 16-bit data lines
// - drive read, write, byte-high, latch, select strobes
// - ready polarity selectable, synchronous or asynchronous
// - asynchronous ready adds a synchronisation waitstate
// - inactive ready adds waitstate, active ends cycle
`timescale 1ns/1ns
`include "ebt_regs.svh"

module ebt_ctrl #(
    parameter int NCS            = 8,
    parameter int LINK_PERIOD_PS = `EBT_LINK_PERIOD_PS
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_sys_rst,
    input  wire logic                      i_clk_en,
    input  wire logic                      i_link_clk,
    input  wire logic                      i_req_valid,
    output logic                           o_req_ready,
    input  wire logic [23:0]               i_req_addr,
    input  wire logic [15:0]               i_req_wdata,
    input  wire logic                      i_req_write,
    input  wire logic [1:0]                i_req_be,
    input  wire logic [2:0]                i_req_cs,
    input  wire logic                      i_mux_mode,
    input  wire logic [NCS*`EBT_CFG_W-1:0] i_chip_select_timing_cfg,
    output logic                           o_rsp_valid,
    output logic [15:0]                    o_rsp_rdata,
    input  wire logic                      i_ready,
    input  wire logic [15:0]               i_data_lines,
    input  wire logic [15:0]               i_shared_addr_data_bus,
    output logic [23:0]                    o_address_lines,
    output logic [15:0]                    o_data_lines,
    output logic                           o_data_lines_oe,
    output logic [15:0]                    o_shared_addr_data_bus,
    output logic                           o_shared_addr_data_bus_oe,
    output logic                           o_rd_n,
    output logic                           o_wr_l_n,
    output logic                           o_wr_h_n,
    output logic                           o_byte_high_enable_n,
    output logic                           o_ale,
    output logic [NCS-1:0]                 o_cs_n,
    output logic                           o_bus_reference_clock
);
    import ebt_pkg::*;

    // one timing unit is one reference clock period, stretched so no two
    // transitions come closer than the minimum gap at fast clocks
    localparam int GAP_CYC = (`EBT_MIN_GAP_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int TU_CYC  = (GAP_CYC > `EBT_REF_CYC) ? GAP_CYC + (GAP_CYC % 2) : `EBT_REF_CYC;
    localparam int RW      = $bits(ebt_req_t);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [15:0] cfg_of(input logic [NCS*`EBT_CFG_W-1:0] all, input logic [2:0] cs);
        return all[cs*`EBT_CFG_W +: `EBT_CFG_W];
    endfunction

    function automatic logic [5:0] phase_units(input ebt_phase_t p, input logic [15:0] c, input logic win);
        logic [5:0] u;
        u = 6'h00;
        unique case (p)
            EBT_ADDR_SETUP:  u = (c[`EBT_CFG_AB_BASE] ? 6'h02 : 6'h01)
                               + (win ? {4'h0, c[`EBT_CFG_AB_EXT_LO +: 2]} : 6'h00);
            EBT_CMD_DELAY:   u = {4'h0, c[`EBT_CFG_C_LO +: 2]};
            EBT_WDATA_SETUP: u = {5'h00, c[`EBT_CFG_D]};
            EBT_ACCESS:      u = {1'b0, c[`EBT_CFG_E_LO +: 5]} + 6'h01;
            EBT_HOLD:        u = {4'h0, c[`EBT_CFG_F_LO +: 2]};
            EBT_READY_WAIT:  u = 6'h01;
            EBT_IDLE:        u = 6'h00;
        endcase
        return u;
    endfunction

    function automatic logic [15:0] load_cnt(input logic [5:0] u);
        return 16'(u * TU_CYC) - 16'h0001;
    endfunction

    // successor of a phase, skipping those programmed to zero
    function automatic ebt_phase_t next_phase(input ebt_phase_t p, input logic [15:0] c);
        ebt_phase_t n;
        n = EBT_IDLE;
        unique case (p)
            EBT_ADDR_SETUP:  n = (c[`EBT_CFG_C_LO +: 2] != 2'h0) ? EBT_CMD_DELAY
                               : (c[`EBT_CFG_D] ? EBT_WDATA_SETUP : EBT_ACCESS);
            EBT_CMD_DELAY:   n = c[`EBT_CFG_D] ? EBT_WDATA_SETUP : EBT_ACCESS;
            EBT_WDATA_SETUP: n = EBT_ACCESS;
            EBT_ACCESS,
            EBT_READY_WAIT:  n = (c[`EBT_CFG_F_LO +: 2] != 2'h0) ? EBT_HOLD : EBT_IDLE;
            EBT_HOLD,
            EBT_IDLE:        n = EBT_IDLE;
        endcase
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // system clock side: buffer and request handshake

    ebt_req_t   in_word;
    ebt_req_t   buf_word;
    logic       buf_valid;
    logic       buf_pop;
    ebt_req_t   hold_q;
    logic       busy_q;
    logic       req_tgl_q;
    logic [2:0] done_sync_q;
    logic       done_tgl_q;
    logic [15:0] rdata_q;

    always_comb begin
        in_word       = '0;
        in_word.cfg   = cfg_of(i_chip_select_timing_cfg, i_req_cs);
        in_word.mux   = i_mux_mode;
        in_word.cs    = i_req_cs;
        in_word.be    = i_req_be;
        in_word.write = i_req_write;
        in_word.wdata = i_req_wdata;
        in_word.addr  = i_req_addr;
    end

    ebt_buf #(
        .WIDTH (RW),
        .DEPTH (`EBT_BUF_DEPTH)
    ) u_buf (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_en      (i_clk_en),
        .i_valid   (i_req_valid),
        .o_ready   (o_req_ready),
        .i_data    (in_word),
        .o_valid   (buf_valid),
        .i_ready   (!busy_q),
        .o_data    (buf_word)
    );

    assign buf_pop = buf_valid && !busy_q;

    // bundled data: hold_q stays still while the toggle crosses
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hold_q      <= '0;
            busy_q      <= 1'b0;
            req_tgl_q   <= 1'b0;
            done_sync_q <= 3'h0;
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= `EBT_DATA_RST;
        end else if (i_clk_en) begin
            done_sync_q <= {done_sync_q[1:0], done_tgl_q};
            o_rsp_valid <= done_sync_q[2] ^ done_sync_q[1];
            if (done_sync_q[2] ^ done_sync_q[1]) begin
                busy_q      <= 1'b0;
                o_rsp_rdata <= rdata_q;
            end
            if (buf_pop) begin
                hold_q    <= buf_word;
                busy_q    <= 1'b1;
                req_tgl_q <= ~req_tgl_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link clock side: reset release, synchronisers, reference clock

    logic [1:0]  lrst_q;
    logic        lrst;
    logic [1:0]  en_sync_q;
    logic        en_l;
    logic [2:0]  req_sync_q;
    logic [2:0]  rdy_sync_q;
    logic [15:0] dl_s1_q;
    logic [15:0] dl_s2_q;
    logic [15:0] ad_s1_q;
    logic [15:0] ad_s2_q;

    always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lrst_q <= 2'h3;
        end else begin
            lrst_q <= {lrst_q[0], 1'b0};
        end
    end
    assign lrst = lrst_q[1];

    always_ff @(posedge i_link_clk or posedge lrst) begin
        if (lrst) begin
            en_sync_q  <= 2'h0;
            req_sync_q <= 3'h0;
            rdy_sync_q <= 3'h0;
            dl_s1_q    <= `EBT_DATA_RST;
            dl_s2_q    <= `EBT_DATA_RST;
            ad_s1_q    <= `EBT_DATA_RST;
            ad_s2_q    <= `EBT_DATA_RST;
        end else begin
            en_sync_q  <= {en_sync_q[0], i_clk_en};
            req_sync_q <= {req_sync_q[1:0], req_tgl_q};
            // third stage is the extra waitstate of asynchronous ready
            rdy_sync_q <= {rdy_sync_q[1:0], i_ready};
            dl_s1_q    <= i_data_lines;
            dl_s2_q    <= dl_s1_q;
            ad_s1_q    <= i_shared_addr_data_bus;
            ad_s2_q    <= ad_s1_q;
        end
    end
    assign en_l = en_sync_q[1];

    always_ff @(posedge i_link_clk or posedge lrst) begin
        if (lrst) begin
            o_bus_reference_clock <= 1'b0;
        end else if (en_l) begin
            o_bus_reference_clock <= ~o_bus_reference_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle sequencer

    ebt_phase_t  state_q;
    ebt_phase_t  state_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    ebt_req_t    word_q;
    ebt_req_t    wd;
    logic [2:0]  last_cs_q;
    logic        win_q;
    logic        new_req;
    logic        phase_end;
    logic        rdy_sel;
    logic        rdy_act;
    logic        acc_done;
    logic        finish;
    logic [1:0]  cap_q;
    logic [1:0]  fin_q;

    assign new_req   = (req_sync_q[2] ^ req_sync_q[1]) && (state_q == EBT_IDLE);
    assign phase_end = (cnt_q == 16'h0000);
    assign wd        = new_req ? hold_q : word_q;
    assign rdy_sel   = word_q.cfg[`EBT_CFG_RDY_ASYNC] ? rdy_sync_q[2] : rdy_sync_q[1];
    assign rdy_act   = (rdy_sel == word_q.cfg[`EBT_CFG_RDY_POL]);
    // access ends at its last unit unless ready is enabled and inactive
    assign acc_done  = phase_end && (!word_q.cfg[`EBT_CFG_RDY_EN] || rdy_act);
    assign finish    = (state_d == EBT_IDLE) && (state_q != EBT_IDLE);

    always_comb begin
        state_d = state_q;
        cnt_d   = phase_end ? cnt_q : cnt_q - 16'h0001;
        unique case (state_q)
            EBT_IDLE: begin
                if (new_req) begin
                    state_d = EBT_ADDR_SETUP;
                    cnt_d   = load_cnt(phase_units(EBT_ADDR_SETUP, hold_q.cfg, hold_q.cs != last_cs_q));
                end
            end
            EBT_ACCESS,
            EBT_READY_WAIT: begin
                if (acc_done) begin
                    state_d = next_phase(state_q, word_q.cfg);
                    cnt_d   = load_cnt(phase_units(state_d, word_q.cfg, win_q));
                end else if (phase_end) begin
                    state_d = EBT_READY_WAIT;
                    cnt_d   = load_cnt(phase_units(EBT_READY_WAIT, word_q.cfg, win_q));
                end
            end
            default: begin
                if (phase_end) begin
                    state_d = next_phase(state_q, word_q.cfg);
                    cnt_d   = (state_d == EBT_IDLE) ? 16'h0000
                            : load_cnt(phase_units(state_d, word_q.cfg, win_q));
                end
            end
        endcase
    end

    always_ff @(posedge i_link_clk or posedge lrst) begin
        if (lrst) begin
            state_q   <= EBT_IDLE;
            cnt_q     <= 16'h0000;
            word_q    <= '0;
            last_cs_q <= 3'h0;
            win_q     <= 1'b0;
        end else if (en_l) begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            if (new_req) begin
                word_q    <= hold_q;
                win_q     <= (hold_q.cs != last_cs_q);
                last_cs_q <= hold_q.cs;
            end
        end
    end

    // pins pass two flops, so the strobe-edge level is taken two edges on
    always_ff @(posedge i_link_clk or posedge lrst) begin
        if (lrst) begin
            rdata_q    <= `EBT_DATA_RST;
            done_tgl_q <= 1'b0;
            cap_q      <= 2'h0;
            fin_q      <= 2'h0;
        end else if (en_l) begin
            cap_q <= {cap_q[0], (state_q == EBT_ACCESS || state_q == EBT_READY_WAIT) && acc_done && !word_q.write};
            fin_q <= {fin_q[0], finish};
            if (cap_q[1]) begin
                rdata_q <= word_q.mux ? ad_s2_q : dl_s2_q;
            end
            if (fin_q[1]) begin
                done_tgl_q <= ~done_tgl_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins, registered from the next phase

    logic strobe_d;
    logic wdrive_d;
    logic active_d;

    assign active_d = (state_d != EBT_IDLE);
    assign strobe_d = (state_d == EBT_ACCESS) || (state_d == EBT_READY_WAIT);
    assign wdrive_d = wd.write && (state_d == EBT_WDATA_SETUP || strobe_d || state_d == EBT_HOLD);

    always_ff @(posedge i_link_clk or posedge lrst) begin
        if (lrst) begin
            o_address_lines           <= `EBT_ADDR_RST;
            o_data_lines              <= `EBT_DATA_RST;
            o_data_lines_oe           <= 1'b0;
            o_shared_addr_data_bus    <= `EBT_DATA_RST;
            o_shared_addr_data_bus_oe <= 1'b0;
            o_rd_n                    <= 1'b1;
            o_wr_l_n                  <= 1'b1;
            o_wr_h_n                  <= 1'b1;
            o_byte_high_enable_n      <= 1'b1;
            o_ale                     <= 1'b0;
            o_cs_n                    <= '1;
        end else if (en_l) begin
            if (active_d) begin
                o_address_lines <= wd.addr;
            end
            o_cs_n <= '1;
            if (active_d) begin
                o_cs_n[wd.cs] <= 1'b0;
            end
            o_rd_n               <= !(strobe_d && !wd.write);
            o_wr_l_n             <= !(strobe_d && wd.write && wd.be[0]);
            o_wr_h_n             <= !(strobe_d && wd.write && wd.be[1]);
            o_byte_high_enable_n <= !(active_d && wd.be[1]);
            o_ale                <= wd.mux && (state_d == EBT_ADDR_SETUP);
            // demux: dedicated data lines for write data
            o_data_lines    <= wd.wdata;
            o_data_lines_oe <= !wd.mux && wdrive_d;
            // mux: address through setup and command delay, then write data
            if (state_d == EBT_ADDR_SETUP || state_d == EBT_CMD_DELAY) begin
                o_shared_addr_data_bus    <= wd.addr[15:0];
                o_shared_addr_data_bus_oe <= wd.mux;
            end else begin
                o_shared_addr_data_bus    <= wd.wdata;
                o_shared_addr_data_bus_oe <= wd.mux && wdrive_d;
            end
        end
    end

endmodule

// ---- verification/ebt_ctrl_chk.sv ----
/* checker of strobes, latch enable and reference clock of ebt_ctrl
   assumes the ports of ebt_ctrl and a free-running link clock */
`timescale 1ns/1ns
module ebt_ctrl_chk #(
    parameter int NCS = 8
) (
    input wire logic           i_link_clk,
    input wire logic           i_sys_rst,
    input wire logic           i_clk_en,
    input wire logic           o_rd_n,
    input wire logic           o_wr_l_n,
    input wire logic           o_wr_h_n,
    input wire logic           o_ale,
    input wire logic [NCS-1:0] o_cs_n,
    input wire logic [15:0]    o_shared_addr_data_bus,
    input wire logic           o_shared_addr_data_bus_oe,
    input wire logic [23:0]    o_address_lines,
    input wire logic           o_data_lines_oe,
    input wire logic           o_bus_reference_clock
);
    default clocking @(posedge i_link_clk); endclocking
    default disable iff (i_sys_rst);
    logic       sel;
    logic [2:0] run_q;
    assign sel = !(&o_cs_n);
    // link reset leaves through a synchroniser, so wait it out
    always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
        if (i_sys_rst) run_q <= 3'h0;
        else if (!i_clk_en) run_q <= 3'h0;
        else if (run_q != 3'h7) run_q <= run_q + 3'h1;
    end
    a_strobe_excl: assert property (!(!o_rd_n && !(o_wr_l_n && o_wr_h_n)))
        else $error("read and write strobe together");
    a_access_min: assert property ($fell(o_rd_n) |-> ##1 !o_rd_n)
        else $error("access shorter than one unit");
    a_setup_first: assert property ($fell(o_rd_n) |-> $past(sel, 2))
        else $error("strobe without address setup");
    a_ale_no_cmd: assert property (o_ale |-> o_rd_n && o_wr_l_n && o_wr_h_n && sel)
        else $error("latch enable outside setup");
    a_ale_addr: assert property (o_ale |-> o_shared_addr_data_bus_oe &&
        o_shared_addr_data_bus == o_address_lines[15:0]) else $error("shared bus not address");
    a_read_float: assert property (!o_rd_n |-> !o_data_lines_oe && !o_shared_addr_data_bus_oe)
        else $error("bus driven during read");
    a_write_drive: assert property (!(o_wr_l_n && o_wr_h_n) |-> o_data_lines_oe || o_shared_addr_data_bus_oe)
        else $error("write data not driven");
    a_ref_toggle: assert property (run_q > 3'h4 |-> o_bus_reference_clock != $past(o_bus_reference_clock))
        else $error("reference clock stuck");
    c_read: cover property ($rose(o_rd_n));
    c_write: cover property ($rose(o_wr_l_n));
    c_mux: cover property ($fell(o_ale));
endmodule
bind ebt_ctrl ebt_ctrl_chk #(.NCS(NCS)) u_chk (.i_link_clk(i_link_clk), .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en), .o_rd_n(o_rd_n), .o_wr_l_n(o_wr_l_n), .o_wr_h_n(o_wr_h_n), .o_ale(o_ale),
    .o_cs_n(o_cs_n), .o_shared_addr_data_bus(o_shared_addr_data_bus), .o_address_lines(o_address_lines),
    .o_shared_addr_data_bus_oe(o_shared_addr_data_bus_oe), .o_data_lines_oe(o_data_lines_oe),
    .o_bus_reference_clock(o_bus_reference_clock));

// ---- verification/ebt_mem.sv ----
/* external memory model: 256 words, byte writes, ready handshake
   assumes strobes of ebt_ctrl and resolved bus levels */
`timescale 1ns/1ns
module ebt_mem (
    input  wire logic        i_link_clk,
    input  wire logic        i_mux,
    input  wire logic        i_rdy_pol,
    input  wire logic [3:0]  i_rdy_wait,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_l_n,
    input  wire logic        i_wr_h_n,
    input  wire logic        i_ale,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_dl,
    input  wire logic [15:0] i_sh,
    output logic      [15:0] o_dl,
    output logic      [15:0] o_sh,
    output logic             o_ready
);
    logic [15:0] mem [256];
    logic [7:0]  lat_q = 8'h00;
    logic [15:0] last_q = 16'h0000;
    logic [3:0]  cnt_q = 4'h0;
    logic [7:0]  idx;
    logic [15:0] wd;
    logic        cmd;
    logic        act;
    assign idx = i_mux ? lat_q : i_addr;
    assign wd = i_mux ? i_sh : i_dl;
    assign cmd = !(i_rd_n && i_wr_l_n && i_wr_h_n);
    assign act = cmd && cnt_q >= i_rdy_wait;
    assign o_ready = i_rdy_pol ? act : !act;
    // released lines show the inverse, never a stale copy
    assign o_dl = i_rd_n ? ~last_q : mem[idx];
    assign o_sh = o_dl;
    initial begin
        for (int k = 0; k < 256; k++) mem[k] = 16'h0000;
    end
    always @(posedge i_link_clk) begin
        cnt_q <= !cmd ? 4'h0 : (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
        if (i_ale) lat_q <= i_sh[7:0];
        if (!i_rd_n) last_q <= mem[idx];
        if (!i_wr_l_n) mem[idx][7:0] <= wd[7:0];
        if (!i_wr_h_n) mem[idx][15:8] <= wd[15:8];
    end
endmodule

// ---- verification/ebt_ctrl_bench.sv ----
/* self-checking bench of ebt_ctrl: random write and read-back cycles
   assumes ebt_mem as the external device and a free link clock */
`timescale 1ns/1ns
module ebt_ctrl_bench;
    logic        i_clk, i_link_clk, i_sys_rst, i_req_valid, i_req_write, i_mux_mode, rdy_pol, bhe_seen;
    logic        o_req_ready, o_rsp_valid, o_data_lines_oe, o_shared_addr_data_bus_oe, o_rd_n;
    logic        o_wr_l_n, o_wr_h_n, o_byte_high_enable_n, o_ale, o_bus_reference_clock, rdy;
    logic [23:0] i_req_addr, o_address_lines;
    logic [15:0] i_req_wdata, o_rsp_rdata, o_data_lines, o_shared_addr_data_bus, m_dl, m_sh, dl_w, sh_w;
    logic [127:0] cfg_v;
    logic [1:0]  i_req_be;
    logic [2:0]  i_req_cs, prev_cs;
    logic [3:0]  rdy_wait;
    logic [7:0]  o_cs_n;
    logic [15:0] exp_mem [256];
    int          num_errors, n_compared, cs_len, cmd_len, cs_cnt, cmd_cnt;
    assign dl_w = o_data_lines_oe ? o_data_lines : m_dl;
    assign sh_w = o_shared_addr_data_bus_oe ? o_shared_addr_data_bus : m_sh;
    ebt_ctrl dut (.*, .i_clk_en(1'b1), .i_chip_select_timing_cfg(cfg_v), .i_ready(rdy), .i_data_lines(dl_w),
        .i_shared_addr_data_bus(sh_w));
    ebt_mem u_mem (.i_link_clk(i_link_clk), .i_mux(i_mux_mode), .i_rdy_pol(rdy_pol), .i_rdy_wait(rdy_wait),
        .i_rd_n(o_rd_n), .i_wr_l_n(o_wr_l_n), .i_wr_h_n(o_wr_h_n), .i_ale(o_ale),
        .i_addr(o_address_lines[7:0]), .i_dl(dl_w), .i_sh(sh_w), .o_dl(m_dl), .o_sh(m_sh), .o_ready(rdy));
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        i_link_clk = 1'b0;
        #37;
        forever #80 i_link_clk = ~i_link_clk;
    end
    // lengths in link cycles of the select and of the command strobes
    always @(posedge i_link_clk) begin
        if (!(&o_cs_n)) begin
            cs_cnt++;
            if (!(o_rd_n && o_wr_l_n && o_wr_h_n)) cmd_cnt++;
            if (!o_byte_high_enable_n) bhe_seen = 1'b1;
        end else if (cs_cnt != 0) begin
            cs_len = cs_cnt;
            cmd_len = cmd_cnt;
            cs_cnt = 0;
            cmd_cnt = 0;
        end
    end
    function automatic int exp_len(logic [15:0] c, bit chg);
        return 2 * (c[0] + 1 + (chg ? c[2:1] : 0) + c[4:3] + c[5] + c[10:6] + 1 + c[12:11]);
    endfunction
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmpn(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input logic wr, input logic [7:0] a, input logic [1:0] be, input logic [2:0] cs,
                       input logic mx, input logic [15:0] c, input logic [3:0] w);
        int          k;
        logic [15:0] wd;
        wd = 16'($urandom);
        @(negedge i_clk);
        cfg_v = {$urandom, $urandom, $urandom, $urandom};
        cfg_v[cs*16 +: 16] = c;
        rdy_pol = c[14];
        rdy_wait = w;
        bhe_seen = 1'b0;
        {i_req_addr, i_req_wdata, i_req_write, i_req_be, i_req_cs, i_mux_mode} = {16'($urandom), a, wd, wr, be, cs, mx};
        i_req_valid = 1'b1;
        for (k = 0; k < 100 && o_req_ready !== 1'b1; k++) @(negedge i_clk);
        @(negedge i_clk);
        i_req_valid = 1'b0;
        for (k = 0; k < 3000 && o_rsp_valid !== 1'b1; k++) @(negedge i_clk);
        cmpn(int'(k < 3000), 1);
        repeat (2) @(posedge i_link_clk);
        if (!wr) cmp16(o_rsp_rdata, exp_mem[a]);
        if (wr && be[0]) exp_mem[a][7:0] = wd[7:0];
        if (wr && be[1]) exp_mem[a][15:8] = wd[15:8];
        cmpn(int'(bhe_seen), int'(be[1]));
        if (!c[13]) begin
            cmpn(cs_len, exp_len(c, cs != prev_cs));
            cmpn(cmd_len, 2 * (c[10:6] + 1));
        end else cmpn(int'(cmd_len > w), 1);
        prev_cs = cs;
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {i_sys_rst, i_req_valid, i_req_addr, i_req_wdata, i_req_write, i_req_be, i_req_cs} = {1'b1, 47'h0};
        {i_mux_mode, cfg_v, rdy_pol, rdy_wait, prev_cs, bhe_seen} = 138'h0;
        {num_errors, n_compared, cs_len, cmd_len, cs_cnt, cmd_cnt} = 192'h0;
        for (int k = 0; k < 256; k++) exp_mem[k] = 16'h0000;
        void'($urandom(67));
        repeat (4) @(negedge i_clk);
        i_sys_rst = 1'b0;
        for (int m = 0; m < 2; m++) begin
            run(1'b1, 8'h5A, 2'b11, 3'h0, m[0], 16'h0000, 4'h0);
            run(1'b0, 8'h5A, 2'b01, 3'h7, m[0], 16'h1FFF, 4'h0);
            run(1'b1, 8'h5A, 2'b10, 3'h7, m[0], 16'h1FFF, 4'h0);
        end
        for (int i = 0; i < 32; i++) begin
            run(1'($urandom), 8'($urandom_range(15)), 2'($urandom_range(3, 1)), 3'($urandom),
                1'($urandom), {3'($urandom) & (i < 24 ? 3'h6 : 3'h7), 16'($urandom) & 13'h1E7F},
                4'($urandom_range(12)));
        end
        tally_and_finish();
    end
endmodule
